// [gtc_consts.svh]
// Purpose: Constant values for the gated sixteen bit timer counter
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef GTC_CONSTS_SVH
`define GTC_CONSTS_SVH

`define GTC_COUNT_RESET   16'h0000
`define GTC_COUNT_MAX     16'hFFFF
`define GTC_COUNT_ONE     16'h0001
`define GTC_PHASE_LAST    2'h3
`define GTC_PHASE_ONE     2'h1
`define GTC_PRESC_ONE     3'h1
`define GTC_PRESC_RESET   3'h0
`define GTC_HIGH_LSB      8
`define GTC_BYTE_W        8

`endif

// [gtc_pkg.sv]
// Purpose: Types shared by the timer counter files
// Assumes: Nothing
// Notes:   Encodings of the clock select field and pulse sequencer
package gtc_pkg;

  typedef enum logic [1:0] {
    SRC_INSTR = 2'b00,
    SRC_SYS   = 2'b01,
    SRC_EXT   = 2'b10,
    SRC_RSVD  = 2'b11
  } clk_src_e;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_WAIT = 2'b01,
    PULSE_RUN  = 2'b10
  } pulse_state_e;

endpackage

// [edge_cond_if.sv]
// Purpose: Carrier between the timer core and the external edge conditioner
// Assumes: One clock domain
// Notes:   Timer drives level and controls, conditioner returns edge pulse
`timescale 1ns/1ps
interface edge_cond_if;
  logic lvl;
  logic sync_en;
  logic disarm;
  logic rise;
  logic armed;
  modport timer (output lvl, output sync_en, output disarm, input rise, input armed);
  modport cond  (input lvl, input sync_en, input disarm, output rise, output armed);
endinterface

// [ext_edge_cond.sv]
// Purpose: Conditions the external count source into a rising edge pulse
// Assumes: Source level arrives synchronous to clk_sys_i on the direct path
// Notes:   A falling edge must be seen before any counting rising edge
`timescale 1ns/1ps
module ext_edge_cond #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  edge_cond_if.cond ec
);
  `include "gtc_consts.svh"

  initial begin
    if (SYNC_STAGES < 2) $error("SYNC_STAGES must be at least 2");
  end

  logic [SYNC_STAGES-1:0] sync_chain;
  logic                   picked;
  logic                   prev;
  logic                   armed;
  logic                   rise;

  // ************************************************************
  // Resampling chain and path select
  // ************************************************************
  // Resample the source; first stage feeds only the next stage
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_chain <= '0;
    end else if (clk_en_i) begin
      sync_chain <= {sync_chain[SYNC_STAGES-2:0], ec.lvl};
    end
  end

  // Synchronized or direct path
  assign picked = ec.sync_en ? sync_chain[SYNC_STAGES-1] : ec.lvl;

  // ************************************************************
  // Edge detection and falling edge arming
  // ************************************************************
  // Previous level and arming; disarm wins over a coincident fall
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev  <= 1'b0;
      armed <= 1'b0;
    end else if (clk_en_i) begin
      prev <= picked;
      if (ec.disarm) begin
        armed <= 1'b0;
      end else if (prev && !picked) begin
        armed <= 1'b1;
      end
    end
  end

  // Rising edge counts only once armed
  assign rise     = armed && !prev && picked && !ec.disarm;
  assign ec.rise  = rise;
  assign ec.armed = armed;

  property p_rise_needs_arm;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      rise |-> $past(armed) || $past(prev && !picked);
  endproperty
  a_rise_needs_arm: assert property (p_rise_needs_arm) else $error("edge counted without a prior fall");

  property p_disarm_clears;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && ec.disarm) |=> !armed;
  endproperty
  a_disarm_clears: assert property (p_disarm_clears) else $error("arming survived disarm");

endmodule // ext_edge_cond

// [gated_timer_counter.sv]
// Purpose: Gated sixteen bit up-counter with selectable count source
// Assumes: clk_sys_i is the system clock; instruction cycle is four clocks
// Notes:   Control bits are plain ports; count bytes written by strobes
`timescale 1ns/1ps
// Contract
// - Sixteen bit up-counter, read and written as high and low bytes.
// - Byte write replaces that byte of the live count at once.
// - Internal instruction source advances once per instruction cycle.
// - External source works as timer or counter on its rising edge.
// - Run clear means off; run alone counts; run with gate enable obeys gate.
// - Select 00 instruction, 01 system, 10 pin or crystal, 11 reserved.
// - Internal sources advance at multiples set by the prescaler.
// - System clock source adds four per instruction cycle.
// - Gate pin event may gate the system clock source.
// - External source counts on rising edge of pin or oscillator.
// - External source has synchronized and direct paths.
// - Crystal oscillator circuit serves as a count source.
// - Counter mode needs a falling edge before first counting rising edge.
// - Single pulse: count from gate rise, clear go and set gate event flag on fall.
module gated_timer_counter #(
  parameter int COUNT_W     = 16,
  parameter int SYNC_STAGES = 2
) (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clk_en_i,
  input  wire logic       wr_high_i,
  input  wire logic       wr_low_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       run_enable_bit_i,
  input  wire logic       gate_enable_bit_i,
  input  wire logic [1:0] clock_select_field_i,
  input  wire logic       crystal_osc_enable_bit_i,
  input  wire logic       ext_sync_enable_i,
  input  wire logic [1:0] prescale_select_i,
  input  wire logic       gate_polarity_bit_i,
  input  wire logic       single_pulse_mode_bit_i,
  input  wire logic       pulse_go_set_i,
  input  wire logic       overflow_flag_clr_i,
  input  wire logic       gate_event_flag_clr_i,
  input  wire logic       external_count_pin_i,
  input  wire logic       crystal_in_pin_i,
  input  wire logic       gate_input_pin_i,
  output logic      [7:0] count_high_byte_o,
  output logic      [7:0] count_low_byte_o,
  output logic            pulse_go_done_bit_o,
  output logic            gate_value_bit_o,
  output logic            overflow_flag_o,
  output logic            gate_event_flag_o,
  output logic            crystal_out_pin_o
);
  `include "gtc_consts.svh"

  initial begin
    if (COUNT_W != 16) $error("COUNT_W must be 16");
  end

  logic [15:0]           count;
  logic [1:0]            phase;
  logic [2:0]            presc;
  logic [2:0]            presc_mask;
  logic                  raw_tick;
  logic                  permit;
  logic                  tick;
  logic                  wr_any;
  logic                  gate_lvl;
  logic                  gate_rise;
  logic                  gate_fall;
  logic                  pulse_end;
  gtc_pkg::clk_src_e     src;
  gtc_pkg::pulse_state_e pstate;

  edge_cond_if ec ();

  // ************************************************************
  // Source selection
  // ************************************************************
  assign src    = gtc_pkg::clk_src_e'(clock_select_field_i);
  assign wr_any = wr_high_i || wr_low_i;

  // Pin or crystal drives the external path
  assign ec.lvl     = crystal_osc_enable_bit_i ? crystal_in_pin_i : external_count_pin_i;
  assign ec.sync_en = ext_sync_enable_i;
  assign ec.disarm  = wr_any || !run_enable_bit_i;

  ext_edge_cond #(
    .SYNC_STAGES(SYNC_STAGES)
  ) u_edge (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i (clk_en_i),
    .ec       (ec.cond)
  );

  // Instruction cycle phase, four system clocks
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase <= 2'h0;
    end else if (clk_en_i) begin
      phase <= phase + `GTC_PHASE_ONE;
    end
  end

  // Raw count events per source
  always_comb begin
    case (src)
      gtc_pkg::SRC_INSTR: raw_tick = (phase == `GTC_PHASE_LAST);
      gtc_pkg::SRC_SYS:   raw_tick = 1'b1;
      gtc_pkg::SRC_EXT:   raw_tick = ec.rise;
      default:            raw_tick = 1'b0;
    endcase
  end

  // ************************************************************
  // Gate logic
  // ************************************************************
  // Polarity picks the permitting level
  assign gate_lvl  = gate_polarity_bit_i ? gate_input_pin_i : !gate_input_pin_i;
  assign gate_rise = gate_lvl && !gate_value_bit_o;
  assign gate_fall = !gate_lvl && gate_value_bit_o;
  assign pulse_end = single_pulse_mode_bit_i && (pstate == gtc_pkg::PULSE_RUN) && gate_fall;

  // Run and gate enables
  always_comb begin
    if (!run_enable_bit_i) begin
      permit = 1'b0;
    end else if (!gate_enable_bit_i) begin
      permit = 1'b1;
    end else if (single_pulse_mode_bit_i) begin
      permit = pulse_go_done_bit_o && (pstate == gtc_pkg::PULSE_RUN) && gate_value_bit_o;
    end else begin
      permit = gate_value_bit_o;
    end
  end

  // Gate value and crystal amplifier output
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate_value_bit_o  <= 1'b0;
      crystal_out_pin_o <= 1'b0;
    end else if (clk_en_i) begin
      gate_value_bit_o  <= gate_lvl;
      crystal_out_pin_o <= crystal_osc_enable_bit_i && !crystal_in_pin_i;
    end
  end

  // Single pulse sequencer
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pstate <= gtc_pkg::PULSE_IDLE;
    end else if (clk_en_i) begin
      case (pstate)
        gtc_pkg::PULSE_IDLE: if (pulse_go_done_bit_o && single_pulse_mode_bit_i) begin
          pstate <= gtc_pkg::PULSE_WAIT;
        end
        gtc_pkg::PULSE_WAIT: if (!single_pulse_mode_bit_i || !pulse_go_done_bit_o) begin
          pstate <= gtc_pkg::PULSE_IDLE;
        end else if (gate_rise) begin
          pstate <= gtc_pkg::PULSE_RUN;
        end
        gtc_pkg::PULSE_RUN: if (!single_pulse_mode_bit_i || gate_fall) begin
          pstate <= gtc_pkg::PULSE_IDLE;
        end
        default: pstate <= gtc_pkg::PULSE_IDLE;
      endcase
    end
  end

  // Go/done: software sets, hardware clears at pulse end
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pulse_go_done_bit_o <= 1'b0;
    end else if (clk_en_i) begin
      if (pulse_end) begin
        pulse_go_done_bit_o <= 1'b0;
      end else if (pulse_go_set_i) begin
        pulse_go_done_bit_o <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Prescaler and counter
  // ************************************************************
  assign presc_mask = 3'((4'h1 << prescale_select_i) - 4'h1);
  assign tick       = raw_tick && permit && ((presc & presc_mask) == presc_mask) && !wr_any;

  // Prescaler advances on each permitted event
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      presc <= `GTC_PRESC_RESET;
    end else if (clk_en_i) begin
      if (wr_any) begin
        presc <= `GTC_PRESC_RESET;
      end else if (raw_tick && permit) begin
        presc <= presc + `GTC_PRESC_ONE;
      end
    end
  end

  // Live count, byte writes take priority
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= `GTC_COUNT_RESET;
    end else if (clk_en_i) begin
      if (wr_high_i) begin
        count[15:`GTC_HIGH_LSB] <= wr_data_i;
      end
      if (wr_low_i) begin
        count[`GTC_HIGH_LSB-1:0] <= wr_data_i;
      end
      if (tick) begin
        count <= count + `GTC_COUNT_ONE;
      end
    end
  end

  // Byte views of the count
  always_comb begin
    count_high_byte_o = count[15:`GTC_HIGH_LSB];
    count_low_byte_o  = count[`GTC_HIGH_LSB-1:0];
  end

  // Sticky flags; hardware set wins over clear
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      overflow_flag_o   <= 1'b0;
      gate_event_flag_o <= 1'b0;
    end else if (clk_en_i) begin
      if (tick && (count == `GTC_COUNT_MAX)) begin
        overflow_flag_o <= 1'b1;
      end else if (overflow_flag_clr_i) begin
        overflow_flag_o <= 1'b0;
      end
      if (pulse_end) begin
        gate_event_flag_o <= 1'b1;
      end else if (gate_event_flag_clr_i) begin
        gate_event_flag_o <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_write_low;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && wr_low_i) |=> count_low_byte_o == $past(wr_data_i);
  endproperty
  a_write_low: assert property (p_write_low) else $error("low byte write lost");

  property p_off_holds;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && !run_enable_bit_i && !wr_any) |=> $stable(count);
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("count moved while off");

  property p_sys_four;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && src == gtc_pkg::SRC_SYS && run_enable_bit_i && !gate_enable_bit_i
       && prescale_select_i == 2'h0 && !wr_any) |=> count == $past(count) + `GTC_COUNT_ONE;
  endproperty
  a_sys_four: assert property (p_sys_four) else $error("system source missed a clock");

  property p_instr_once;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && src == gtc_pkg::SRC_INSTR && phase != `GTC_PHASE_LAST && !wr_any) |=> $stable(count);
  endproperty
  a_instr_once: assert property (p_instr_once) else $error("instruction source counted mid cycle");

  property p_overflow;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && tick && count == `GTC_COUNT_MAX) |=> overflow_flag_o && count == `GTC_COUNT_RESET;
  endproperty
  a_overflow: assert property (p_overflow) else $error("wrap did not set overflow");

  property p_gate_blocks;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && gate_enable_bit_i && !single_pulse_mode_bit_i && !gate_value_bit_o && !wr_any)
      |=> $stable(count);
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("count moved with gate closed");

  property p_pulse_end;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && pulse_end) |=> !pulse_go_done_bit_o && gate_event_flag_o;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse end not signalled");

  property p_ext_rise;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && src == gtc_pkg::SRC_EXT && ec.rise && run_enable_bit_i && !gate_enable_bit_i
       && prescale_select_i == 2'h0 && !wr_any) |=> count == $past(count) + `GTC_COUNT_ONE;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("external edge not counted");

endmodule // gated_timer_counter

// [ext_source_model.sv]
// Purpose: Far side model: count pin, crystal input and gate pin
// Assumes: Levels change just after a rising clk_sys_i edge
// Notes:   Pins hold their level between pulses, as a clock pin does
`timescale 1ns/1ps
// ****************************************
// Source model
// ****************************************
module ext_source_model (
  input  wire logic clk_sys_i,
  output logic      ext_pin_o,
  output logic      xtal_pin_o,
  output logic      gate_pin_o
);
  // All pins idle low
  initial begin
    ext_pin_o  = 1'h0;
    xtal_pin_o = 1'h0;
    gate_pin_o = 1'h0;
  end
  // Rise then fall n times, each level held half cycles; slow when half is large
  task automatic pulses(input bit xtal, input int n, input int half);
    repeat (2 * n) begin
      @(posedge clk_sys_i);
      #1;
      if (xtal)
        xtal_pin_o = ~xtal_pin_o;
      else
        ext_pin_o = ~ext_pin_o;
      repeat (half - 1) @(posedge clk_sys_i);
    end
  endtask
  // Gate level for the single pulse sequence
  task automatic set_gate(input bit lvl);
    @(posedge clk_sys_i);
    #1;
    gate_pin_o = lvl;
  endtask
endmodule // ext_source_model

// [testbench.sv]
// Purpose: Self-checking bench for the gated timer counter
// Assumes: Inputs change 1 ns after the rising clock edge
// Notes:   Table rows cover sources, enables and prescale; hand tests follow
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module testbench;
  typedef struct packed {
    logic [1:0]  src;
    logic        run;
    logic        ge;
    logic        pol;
    logic [1:0]  ps;
    logic        en;
    logic [15:0] exp;
  } row_s;
  logic        clk_sys_i = 1'h0;
  logic        sys_rst_i = 1'h1;
  logic        clk_en = 1'h1;
  logic        wr_high = 1'h0;
  logic        wr_low = 1'h0;
  logic [7:0]  wr_data = 8'h00;
  logic        run = 1'h0;
  logic        ge = 1'h0;
  logic [1:0]  src = 2'h1;
  logic        osc_en = 1'h0;
  logic        sync = 1'h0;
  logic [1:0]  ps = 2'h0;
  logic        pol = 1'h1;
  logic        spm = 1'h0;
  logic        go_set = 1'h0;
  logic        ovf_clr = 1'h0;
  logic        gev_clr = 1'h0;
  logic        ext_pin, xtal_pin, gate_pin;
  logic [7:0]  hi, lo;
  logic        go_done, gate_val, ovf, gev, xtal_out;
  logic [15:0] cnt;
  logic [15:0] snap;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          i;
  row_s rows [9] = '{
    '{2'h1, 1'h1, 1'h0, 1'h1, 2'h0, 1'h1, 16'h0010},
    '{2'h0, 1'h1, 1'h0, 1'h1, 2'h0, 1'h1, 16'h0004},
    '{2'h1, 1'h1, 1'h0, 1'h1, 2'h2, 1'h1, 16'h0004},
    '{2'h1, 1'h1, 1'h0, 1'h1, 2'h3, 1'h1, 16'h0002},
    '{2'h3, 1'h1, 1'h0, 1'h1, 2'h0, 1'h1, 16'h0000},
    '{2'h1, 1'h0, 1'h1, 1'h0, 2'h0, 1'h1, 16'h0000},
    '{2'h1, 1'h1, 1'h1, 1'h1, 2'h0, 1'h1, 16'h0000},
    '{2'h1, 1'h1, 1'h1, 1'h0, 2'h0, 1'h1, 16'h0010},
    '{2'h1, 1'h1, 1'h0, 1'h1, 2'h0, 1'h0, 16'h0000}};
  assign cnt = {hi, lo};
  // 40 MHz system clock
  always #12.5 clk_sys_i = ~clk_sys_i;
  ext_source_model partner (
    .clk_sys_i  (clk_sys_i),
    .ext_pin_o  (ext_pin),
    .xtal_pin_o (xtal_pin),
    .gate_pin_o (gate_pin)
  );
  gated_timer_counter dut (
    .clk_sys_i                (clk_sys_i),
    .sys_rst_i                (sys_rst_i),
    .clk_en_i                 (clk_en),
    .wr_high_i                (wr_high),
    .wr_low_i                 (wr_low),
    .wr_data_i                (wr_data),
    .run_enable_bit_i         (run),
    .gate_enable_bit_i        (ge),
    .clock_select_field_i     (src),
    .crystal_osc_enable_bit_i (osc_en),
    .ext_sync_enable_i        (sync),
    .prescale_select_i        (ps),
    .gate_polarity_bit_i      (pol),
    .single_pulse_mode_bit_i  (spm),
    .pulse_go_set_i           (go_set),
    .overflow_flag_clr_i      (ovf_clr),
    .gate_event_flag_clr_i    (gev_clr),
    .external_count_pin_i     (ext_pin),
    .crystal_in_pin_i         (xtal_pin),
    .gate_input_pin_i         (gate_pin),
    .count_high_byte_o        (hi),
    .count_low_byte_o         (lo),
    .pulse_go_done_bit_o      (go_done),
    .gate_value_bit_o         (gate_val),
    .overflow_flag_o          (ovf),
    .gate_event_flag_o        (gev),
    .crystal_out_pin_o        (xtal_out)
  );
  // Advance n edges, then settle past them
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Stop counting and load both bytes with one value
  task automatic load(input logic [7:0] d);
    run     = 1'h0;
    wr_high = 1'h1;
    wr_low  = 1'h1;
    wr_data = d;
    step(1);
    wr_high = 1'h0;
    wr_low  = 1'h0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(25 * 20000);
    error_cnt++;
    summarize();
  end
  // Main sequence
  initial begin
    step(20);
    chk("reset count", 16'h0000, cnt);
    chk("reset flags", 16'h0000, {12'h000, go_done, gate_val, ovf, gev});
    sys_rst_i = 1'h0;
    step(2);
    // Table: 16 edges of counting per row
    for (i = 0; i < 9; i++) begin
      load(8'h00);
      src = rows[i].src;
      ge  = rows[i].ge;
      pol = rows[i].pol;
      ps  = rows[i].ps;
      step(1);
      run    = rows[i].run;
      clk_en = rows[i].en;
      step(16);
      run    = 1'h0;
      clk_en = 1'h1;
      step(2);
      chk($sformatf("row %0d", i), rows[i].exp, cnt);
    end
    // Back to back byte writes
    ge = 1'h0;
    ps = 2'h0;
    wr_low  = 1'h1;
    wr_data = 8'h3C;
    step(1);
    wr_low  = 1'h0;
    wr_high = 1'h1;
    wr_data = 8'hA5;
    step(1);
    wr_high = 1'h0;
    step(1);
    chk("byte write", 16'hA53C, cnt);
    // Wrap through all ones; flag sticks until cleared
    load(8'hFF);
    step(1);
    wr_low  = 1'h1;
    wr_data = 8'hFE;
    step(1);
    wr_low = 1'h0;
    run    = 1'h1;
    step(3);
    run = 1'h0;
    step(5);
    chk("wrap count", 16'h0001, cnt);
    chk("ovf held", 16'h0001, {15'h0000, ovf});
    ovf_clr = 1'h1;
    step(1);
    ovf_clr = 1'h0;
    step(1);
    chk("ovf clear", 16'h0000, {15'h0000, ovf});
    // External pin and crystal, direct and synchronized, fast and slow
    src = 2'h2;
    for (i = 0; i < 4; i++) begin
      osc_en = i[0];
      sync   = i[1];
      load(8'h00);
      step(2);
      if (i[0])
        chk("xtal out", 16'h0001, {15'h0000, xtal_out});
      run = 1'h1;
      partner.pulses(i[0], 4, i[1] ? 5 : 2);
      step(8);
      chk($sformatf("ext %0d", i), 16'h0003, cnt);
    end
    // Single pulse gate: wait for go, count one gate window only
    osc_en = 1'h0;
    src = 2'h1;
    ge  = 1'h1;
    spm = 1'h1;
    pol = 1'h1;
    load(8'h00);
    run = 1'h1;
    step(4);
    chk("no go", 16'h0000, cnt);
    go_set = 1'h1;
    step(1);
    go_set = 1'h0;
    step(2);
    chk("go set", 16'h0001, {15'h0000, go_done});
    partner.set_gate(1'h1);
    step(3);
    chk("gate value", 16'h0001, {15'h0000, gate_val});
    partner.set_gate(1'h0);
    step(4);
    chk("go done", 16'h0001, {14'h0000, go_done, gev});
    // Gate pin stood high for four clocks, so four system clock counts
    chk("pulse count", 16'h0004, cnt);
    snap = cnt;
    partner.set_gate(1'h1);
    step(3);
    partner.set_gate(1'h0);
    step(3);
    chk("second pulse", snap, cnt);
    gev_clr = 1'h1;
    step(1);
    gev_clr = 1'h0;
    step(1);
    chk("gev clear", 16'h0000, {15'h0000, gev});
    // Reset in mid count clears at once
    ge  = 1'h0;
    spm = 1'h0;
    step(3);
    sys_rst_i = 1'h1;
    #1;
    chk("mid reset", 16'h0000, cnt);
    step(2);
    sys_rst_i = 1'h0;
    step(2);
    chk("count after reset", 16'h0002, cnt);
    summarize();
  end
endmodule // testbench
